// ==== hw/afc_flow_ctrl.sv ====
// Purpose: automatic receive flow control: pause frames and half-duplex jamming
// Assumes: fifo level in bytes; rx frame class pulses from the receive filter
// Notes: pause requests are held until the mac takes them with pause_ack or tx_enabled drops
`timescale 1ns/1ps
module afc_flow_ctrl (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic [afc_pkg::FIFO_LEVEL_W-1:0] rx_fifo_level,
    input wire logic full_duplex,
    input wire logic speed_10,
    input wire logic tx_enabled,
    input wire logic rx_preamble,
    input wire logic rx_frame_mcast,
    input wire logic rx_frame_bcast,
    input wire logic rx_frame_own,
    output logic pause_req,
    output logic pause_zero,
    input wire logic pause_ack,
    output logic back_pressure,
    output logic pause_sent
);
    typedef struct packed {
        logic [31:0] cfg;
        logic req;
        logic zero;
        logic sent;
        logic [31:0] rdata;
    } afc_fc_state_t;

    afc_fc_state_t s_q;
    afc_fc_state_t s_d;
    afc_jam_if jam ();

    logic [7:0] hi_lvl;
    logic [7:0] lo_lvl;
    logic [7:0] fill_units;
    logic above_hi;
    logic below_lo;
    logic afc_en;
    logic jam_match;

    // one decode shared by the write and read paths so they never disagree
    function automatic logic cfg_hit(input logic [7:0] addr);
        cfg_hit = (addr == afc_pkg::CONFIG_OFFSET);
    endfunction

    afc_jam_timer afc_jam_timer_i (
        .ref_clk(ref_clk),
        .rst(rst),
        .jam(jam)
    );

    always_comb
    begin
        hi_lvl = s_q.cfg[afc_pkg::HI_MSB:afc_pkg::HI_LSB];
        lo_lvl = s_q.cfg[afc_pkg::LO_MSB:afc_pkg::LO_LSB];
        // a 14-bit byte level in 64-byte units fits the 8-bit threshold fields exactly
        fill_units = rx_fifo_level[afc_pkg::FIFO_LEVEL_W-1:afc_pkg::UNIT_SHIFT];
        above_hi = fill_units >= hi_lvl;
        below_lo = fill_units < lo_lvl;
        afc_en = |s_q.cfg[afc_pkg::MULT_BIT:afc_pkg::ANY_BIT];
        if (s_q.cfg[afc_pkg::ANY_BIT])
        begin
            jam_match = rx_preamble;
        end
        else
        begin
            jam_match = (s_q.cfg[afc_pkg::MULT_BIT] && rx_frame_mcast)
                || (s_q.cfg[afc_pkg::BRD_BIT] && rx_frame_bcast)
                || (s_q.cfg[afc_pkg::ADDR_BIT] && rx_frame_own);
        end
    end

    assign jam.code = s_q.cfg[afc_pkg::DUR_MSB:afc_pkg::DUR_LSB];
    assign jam.slow = speed_10;
    // half duplex only; a busy timer absorbs a new match rather than restarting
    assign jam.start = !full_duplex && tx_enabled && above_hi && jam_match;

    always_comb
    begin
        s_d = s_q;
        if (reg_wr && cfg_hit(reg_addr))
        begin
            s_d.cfg = reg_wdata & afc_pkg::CFG_WMASK;
        end
        s_d.rdata = '0;
        if (reg_rd && cfg_hit(reg_addr))
        begin
            s_d.rdata = s_q.cfg;
        end
        if (s_q.req && pause_ack)
        begin
            s_d.req = 1'b0;
            s_d.sent = !s_q.zero;
        end
        if (!tx_enabled)
        begin
            s_d.req = 1'b0;
        end
        else if (!s_q.req && full_duplex)
        begin
            // only bit 0 arms full-duplex pause; low-level check uses the sent flag
            if (!s_q.sent && above_hi && s_q.cfg[afc_pkg::ANY_BIT])
            begin
                s_d.req = 1'b1;
                s_d.zero = 1'b0;
            end
            else if (s_q.sent && below_lo && afc_en)
            begin
                s_d.req = 1'b1;
                s_d.zero = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_q.cfg <= afc_pkg::CFG_RESET;
            s_q.req <= 1'b0;
            s_q.zero <= 1'b0;
            s_q.sent <= 1'b0;
            s_q.rdata <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign pause_req = s_q.req;
    assign pause_zero = s_q.zero;
    assign pause_sent = s_q.sent;
    assign back_pressure = jam.busy && tx_enabled;
endmodule

// ==== include/afc_pkg.sv ====
// Purpose: constants and types for the automatic receive flow control block
// Assumes: 100 MHz ref_clk, register reached through a plain word port
// Notes: thresholds count 64-byte units of the receive data fifo
package afc_pkg;
    localparam logic [7:0] CONFIG_OFFSET = 8'hac;
    localparam int HI_MSB = 23;
    localparam int HI_LSB = 16;
    localparam int LO_MSB = 15;
    localparam int LO_LSB = 8;
    localparam int DUR_MSB = 7;
    localparam int DUR_LSB = 4;
    localparam int MULT_BIT = 3;
    localparam int BRD_BIT = 2;
    localparam int ADDR_BIT = 1;
    localparam int ANY_BIT = 0;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_WMASK = 32'h00ff_ffff;
    localparam int FIFO_LEVEL_W = 14;
    localparam int UNIT_SHIFT = 6;
    localparam int CLK_MHZ = 100;
    localparam int JAM_CNT_W = 17;
    // 10 Mb/s extra 2.2 us, held in ns
    localparam int SLOW_EXTRA_NS = 2200;
    localparam int SLOW_EXTRA_CYC = (SLOW_EXTRA_NS * CLK_MHZ) / 1000;
    localparam int JAM_STEP_US = 50;

    typedef enum logic [1:0] {
        AFC_IDLE = 2'b00,
        AFC_PAUSED = 2'b01
    } afc_state_t;

    // duration code to microseconds
    function automatic int jam_us(input logic [3:0] code);
        case (code)
            4'h0: jam_us = 5;
            4'h1: jam_us = 10;
            4'h2: jam_us = 15;
            4'h3: jam_us = 25;
            default: jam_us = JAM_STEP_US * (int'(code) - 3);
        endcase
    endfunction
endpackage

// ==== include/afc_jam_if.sv ====
// Purpose: carries a jam request to the jam timer and its busy state back
// Assumes: single clock domain
// Notes: start is a one-cycle pulse
`timescale 1ns/1ps
interface afc_jam_if;
    logic start;
    logic [3:0] code;
    logic slow;
    logic busy;
    modport ctrl (output start, output code, output slow, input busy);
    modport timer (input start, input code, input slow, output busy);
endinterface

// ==== hw/afc_jam_timer.sv ====
// Purpose: holds back pressure for the programmed duration
// Assumes: start may pulse while busy; such a start is ignored
// Notes: duration fixed at start; later code changes wait for the next jam
`timescale 1ns/1ps
module afc_jam_timer (
    input wire logic ref_clk,
    input wire logic rst,
    afc_jam_if.timer jam
);
    typedef struct packed {
        logic [afc_pkg::JAM_CNT_W-1:0] cnt;
        logic busy;
    } afc_jt_state_t;

    afc_jt_state_t s_q;
    afc_jt_state_t s_d;

    function automatic logic [afc_pkg::JAM_CNT_W-1:0] jam_cycles(input logic [3:0] code,
                                                                  input logic slow);
        int c;
        c = afc_pkg::jam_us(code) * afc_pkg::CLK_MHZ;
        if (slow)
        begin
            c = c + afc_pkg::SLOW_EXTRA_CYC;
        end
        // longest code at 10 Mb/s stays well inside the counter width
        jam_cycles = c[afc_pkg::JAM_CNT_W-1:0];
    endfunction

    always_comb
    begin
        s_d = s_q;
        if (jam.start && !s_q.busy)
        begin
            s_d.cnt = jam_cycles(jam.code, jam.slow) - 1'b1;
            s_d.busy = 1'b1;
        end
        else if (s_q.busy)
        begin
            if (s_q.cnt == '0)
            begin
                s_d.busy = 1'b0;
            end
            else
            begin
                s_d.cnt = s_q.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign jam.busy = s_q.busy;
endmodule

// ==== bench/afc_flow_ctrl_assertions.sv ====
// Purpose: port checks of automatic flow control
// Assumes: one ref_clk domain
// Notes: jam length is checked by the bench
`timescale 1ns/1ps
module afc_flow_ctrl_assertions (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic full_duplex,
    input wire logic tx_enabled,
    input wire logic pause_req,
    input wire logic pause_zero,
    input wire logic pause_ack,
    input wire logic back_pressure,
    input wire logic pause_sent
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_tx_off; !tx_enabled |-> !back_pressure; endproperty
    a_tx_off: assert property (p_tx_off) else $error("jam with tx off");
    property p_tx_req; !tx_enabled |=> !pause_req; endproperty
    a_tx_req: assert property (p_tx_req) else $error("pause with tx off");
    property p_hold; pause_req && !pause_ack && tx_enabled |=> pause_req; endproperty
    a_hold: assert property (p_hold) else $error("pause dropped");
    property p_one; pause_sent |-> !(pause_req && !pause_zero); endproperty
    a_one: assert property (p_one) else $error("second timed pause");
    property p_set; pause_req && !pause_zero && pause_ack |=> pause_sent && !pause_req; endproperty
    a_set: assert property (p_set) else $error("flag not set");
    property p_zero; $rose(pause_req) && pause_zero |-> pause_sent; endproperty
    a_zero: assert property (p_zero) else $error("zero pause unarmed");
    property p_clr; pause_req && pause_zero && pause_ack |=> !pause_sent; endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared");
    property p_fd; full_duplex && tx_enabled && !back_pressure |=> !back_pressure; endproperty
    a_fd: assert property (p_fd) else $error("jam in full duplex");
endmodule

// ==== bench/afc_mac_model.sv ====
// Purpose: stand-in mac that takes pause requests
// Assumes: pause_ack is a one-cycle pulse
// Notes: dly sets a prompt or slow transmit window
`timescale 1ns/1ps
module afc_mac_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] dly,
    input wire logic pause_req,
    output logic pause_ack
);
    logic [3:0] cnt_q;
    // no ack until the request has waited for its window
    always_ff @(posedge ref_clk)
    begin
        cnt_q <= (rst || !pause_req || pause_ack) ? 4'h0 : cnt_q + 4'h1;
        pause_ack <= !rst && pause_req && !pause_ack && (cnt_q == dly);
    end
endmodule

// ==== bench/afc_flow_ctrl_tb.sv ====
// Purpose: register, pause and jam tests of automatic flow control
// Assumes: mac model answers pause requests
// Notes: long jam codes skipped to keep the run short
`timescale 1ns/1ps
module afc_flow_ctrl_tb;
    logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, fd = 1, s10 = 0, txe = 1;
    logic pre = 0, mc = 0, bc = 0, own = 0, req, zero, ack, bp, sent;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
    logic [13:0] lvl = 14'h0;
    logic [3:0] dly = 4'h1;
    int miscompares = 0, n_compared = 0, cyc = 0, n;
    afc_flow_ctrl afc_flow_ctrl_i (.ref_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .rx_fifo_level(lvl), .full_duplex(fd), .speed_10(s10), .tx_enabled(txe),
        .rx_preamble(pre), .rx_frame_mcast(mc), .rx_frame_bcast(bc), .rx_frame_own(own),
        .pause_req(req), .pause_zero(zero), .pause_ack(ack), .back_pressure(bp),
        .pause_sent(sent));
    afc_mac_model afc_mac_model_i (.ref_clk, .rst, .dly, .pause_req(req), .pause_ack(ack));
    initial forever #5 ref_clk = ~ref_clk;
    task automatic close_out;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            close_out;
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            miscompares++;
            $display("[FAIL] %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 0;
        reg_rd <= 0;
        #1 v = reg_rdata;
    endtask
    task automatic wt(input logic [1:0] e);
        n = 0;
        while ({req, sent} !== e && n < 60)
        begin
            idle(1);
            n++;
        end
        chk("req sent", {req, sent}, e);
    endtask
    // a preamble or class pulse, then count the jam cycles
    task automatic jam(input int k, input int e);
        @(posedge ref_clk);
        {own, bc, mc, pre} <= 4'h1 << k;
        @(posedge ref_clk);
        {own, bc, mc, pre} <= 4'h0;
        n = 0;
        // first look is just after the edge that takes the pulse
        repeat (e + 20)
        begin
            #1;
            n += (bp === 1'b1);
            @(posedge ref_clk);
        end
        chk("jam cycles", n, e);
    endtask
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst <= 0;
        acc(0, 8'hac, 0);
        chk("cfg reset", v, afc_pkg::CFG_RESET);
        acc(1, 8'hac, 32'hff02_0101);
        acc(1, 8'ha8, 32'h1234_5678);
        acc(0, 8'ha8, 0);
        chk("unmapped", v, 32'h0);
        acc(0, 8'hac, 0);
        chk("cfg", v, 32'h0002_0101);
        idle(10);
        chk("no zero", req, 1'b0);
        lvl <= 14'h7f;
        idle(10);
        chk("below hi", req, 1'b0);
        lvl <= 14'h80;
        wt(2'b10);
        chk("timed", zero, 1'b0);
        wt(2'b01);
        idle(20);
        chk("single", req, 1'b0);
        lvl <= 14'h40;
        idle(10);
        chk("at lo", req, 1'b0);
        lvl <= 14'h3f;
        wt(2'b11);
        chk("zero", zero, 1'b1);
        wt(2'b00);
        txe <= 0;
        dly <= 4'h8;
        lvl <= 14'h80;
        idle(20);
        chk("tx off", req, 1'b0);
        txe <= 1;
        wt(2'b01);
        lvl <= 14'h0;
        wt(2'b00);
        fd <= 0;
        lvl <= 14'h80;
        for (int k = 0; k < 4; k++)
        begin
            acc(1, 8'hac, 32'h0002_0100 | (32'h1 << (k == 0 ? 0 : 4 - k)));
            jam(k, 500);
            if (k > 0)
                jam(k % 3 + 1, 0);
        end
        acc(1, 8'hac, 32'h0002_0112);
        s10 <= 1;
        jam(3, 1220);
        s10 <= 0;
        acc(1, 8'hac, 32'h0002_0122);
        jam(3, 1500);
        acc(1, 8'hac, 32'h0002_0132);
        jam(3, 2500);
        acc(1, 8'hac, 32'h0002_0142);
        jam(3, 5000);
        txe <= 0;
        jam(3, 0);
        txe <= 1;
        fd <= 1;
        jam(3, 0);
        close_out;
    end
endmodule
bind afc_flow_ctrl afc_flow_ctrl_assertions afc_flow_ctrl_assertions_i (
    .ref_clk(ref_clk),
    .rst(rst),
    .full_duplex(full_duplex),
    .tx_enabled(tx_enabled),
    .pause_req(pause_req),
    .pause_zero(pause_zero),
    .pause_ack(pause_ack),
    .back_pressure(back_pressure),
    .pause_sent(pause_sent)
);
